// File: pkg/reset_ctrl_map.vh
`ifndef RESET_CTRL_MAP_VH
`define RESET_CTRL_MAP_VH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define IDX_OPTION_SELECT    16'h0094
`define IDX_SOFTWARE_COMMAND 16'h0097
`define IDX_AUX_CONTROL_TWO  16'h00F7
`define IDX_AUX_CONTROL_ONE  16'h00F8
`define IDX_CONFIG_WORD_HIGH 16'h3FFF
`define IDX_RESET_CAUSE      16'h0090

// ==========================================================
// Field positions and reset values
// ==========================================================
`define OPT_PERIOD_HI     5
`define OPT_PERIOD_LO     4
`define OPT_WRITE_MASK    8'hBC
`define OPT_RESET         8'h00
`define SW_RESET_CODE     8'h56
`define AUX_CONTROL_TWO_DOG_EN_HI    7
`define AUX_CONTROL_TWO_DOG_EN_LO    6
`define AUX_CONTROL_TWO_POWER_SAVE   5
`define AUX_CONTROL_TWO_LOW_OFF      0
`define AUX_CONTROL_TWO_WRITE_MASK   8'hF7
`define AUX_CONTROL_TWO_RESET        8'h06
`define AUX_CONTROL_ONE_DOG_CLEAR    7
`define AUX_CONTROL_ONE_RESET        8'h00
`define CFG_PIN_RST_EN    6
`define CFG_LEVEL_HI      5
`define CFG_LEVEL_LO      3
`define CFG_BYTES         6
`define CFG_BASE_ADDR     16'h3FFA
`define DOG_EN_ALWAYS     2'b11
`define DOG_EN_RUN        2'b10

// ==========================================================
// Timing
// ==========================================================
`define CLK_KHZ           40000
`define SLOW_RC_KHZ       68
`define WARMUP_MS         40
`define WARMUP_CYCLES     (`WARMUP_MS * `CLK_KHZ)
`define DOG_SHORT_MS      60
`define DOG_SHORT_TICKS   (`DOG_SHORT_MS * `SLOW_RC_KHZ)
`define PIN_LOW_TICKS     2
`define RELEASE_TICKS     2

`endif

// File: src/reset_source_and_watchdog_ctrl.v
// Operation
// - Five sources reset device and load register defaults; only power-on clears reset cause
// - Power-on holds reset for 40 ms warm-up
// - After warm-up load six config bytes
// - Writing 56h to command register resets
// - Watchdog counts slow RC ticks, mode dependent
// - Period select: 480, 240, 120, 60 ms
// - Enable field: 0x off, 10 run, 11 always
// - Clear bit resets counter, self-clears next cycle
// - Any device reset clears watchdog counter
// - Three-bit field selects low-voltage trip level
// - Enabled watchdog overflow causes device reset
// - Power save disables low-voltage reset when sleeping
// - In reset force slow mode on RC
`timescale 1ns/10ps
`include "reset_ctrl_map.vh"

module reset_source_and_watchdog_ctrl #(
   parameter WARMUP_CYCLES  = `WARMUP_CYCLES,   // Power-on warm-up
   parameter DOG_BASE_TICKS = `DOG_SHORT_TICKS  // Shortest dog period
) (
   input  wire        clk,           // 40 MHz system clock
   input  wire        arst_n,        // Power-on reset, active low
   input  wire        psel,          // APB select
   input  wire        penable,       // APB access phase
   input  wire        pwrite,        // APB direction
   input  wire [15:0] paddr,         // APB byte address
   input  wire [31:0] pwdata,        // APB write data
   output reg  [31:0] prdata,        // APB read data
   output reg         pready,        // APB ready
   output reg         pslverr,       // APB error, unmapped
   input  wire        ext_pin_rst_n, // External reset pin
   input  wire        slow_rc_osc,   // Slow RC oscillator, 68 kHz
   input  wire        lowSupply,     // Supply below selected level
   input  wire [1:0]  cpuMode,       // 0 fast,1 slow,2 idle,3 stop
   output reg  [15:0] cfgAddr,       // Config byte address
   output reg         cfgRead,       // Config byte read strobe
   input  wire [7:0]  cfgRdData,     // Config byte, one cycle later
   output reg         devRst_n,      // Device reset, active low
   output reg         slowModeForce, // Hold clocking at slow RC
   output reg  [2:0]  low_supply_level_sel // Trip level select
);

   // =======================================================
   // Local constants
   // =======================================================
   localparam [1:0] ST_WARM = 2'd0;   // Power-on warm-up
   localparam [1:0] ST_LOAD = 2'd1;   // Config byte fetch
   localparam [1:0] ST_HOLD = 2'd2;   // Reset held
   localparam [1:0] ST_RUN  = 2'd3;   // Normal operation
   localparam [1:0] MODE_IDLE = 2'd2; // First sleeping mode

   // Byte address from register index
   function [15:0] byteAddr;
      input [15:0] idx;
      begin
         byteAddr = {idx[13:0], 2'b00};
      end
   endfunction

   // =======================================================
   // Declarations
   // =======================================================
   reg  [1:0]  state;          // Sequencer state
   reg  [20:0] warmCount;      // Warm-up cycle counter
   reg  [2:0]  loadIdx;        // Config byte index
   reg         loadPend;       // Read data due this cycle
   reg  [7:0]  configWords [0:`CFG_BYTES-1]; // Loaded bytes
   reg  [1:0]  releaseTicks;   // Slow ticks since sources left
   reg  [7:0]  option_select;  // Period select and storage
   reg  [7:0]  aux_control_two;// Enables and power save
   reg  [7:0]  aux_control_one;// Clear bit and storage
   reg  [3:0]  resetCause;     // Sticky last cause
   reg         swReq;          // Software reset pulse
   reg  [15:0] watchdog_counter; // Slow tick counter
   reg         dogReq;         // Watchdog overflow pulse
   reg  [1:0]  pinLowCount;    // Slow ticks with pin low
   reg         pinSync1;       // Pin sync stage 1
   reg         pinSync2;       // Pin sync stage 2
   reg         rcSync1;        // Slow clock sync stage 1
   reg         rcSync2;        // Slow clock sync stage 2
   reg         rcPrev;         // Slow clock previous level
   reg         lowSync1;       // Supply sync stage 1
   reg         lowSync2;       // Supply sync stage 2
   integer     i;              // Array loop index

   wire        slowTick;       // One cycle per slow rising edge
   wire        sleeping;       // Idle or stop
   wire        pinRstOn;       // Pin reset enabled
   wire        extReq;         // Pin reset held
   wire        lowReq;         // Low-voltage reset active
   wire        anyReq;         // Any run-time source
   wire        inReset;        // Registers held at defaults
   wire        apbDone;        // Access completes this edge
   wire        apbWr;          // Write takes effect
   wire [1:0]  dogEn;          // Watchdog reset enable
   wire        dogRun;         // Watchdog counting allowed
   wire [15:0] dogLimit;       // Last count before overflow
   wire        mapped;         // Address hits a register
   reg  [7:0]  rdByte;         // Read mux

   assign slowTick = rcSync2 & ~rcPrev;
   assign sleeping = (cpuMode >= MODE_IDLE);
   assign pinRstOn = configWords[`CFG_BYTES-1][`CFG_PIN_RST_EN];
   assign inReset  = (state != ST_RUN);
   assign apbDone  = psel & penable & pready;
   assign apbWr    = apbDone & pwrite & mapped & ~inReset;
   assign dogEn    = aux_control_two[`AUX_CONTROL_TWO_DOG_EN_HI:`AUX_CONTROL_TWO_DOG_EN_LO];

   // =======================================================
   // Input synchronisers
   // =======================================================
   // Two flops ahead of any logic for pin, slow clock, supply
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinSync1 <= 1'b1;
         pinSync2 <= 1'b1;
         rcSync1  <= 1'b0;
         rcSync2  <= 1'b0;
         rcPrev   <= 1'b0;
         lowSync1 <= 1'b0;
         lowSync2 <= 1'b0;
      end else begin
         pinSync1 <= ext_pin_rst_n;
         pinSync2 <= pinSync1;
         rcSync1  <= slow_rc_osc;
         rcSync2  <= rcSync1;
         rcPrev   <= rcSync2;
         lowSync1 <= lowSupply;
         lowSync2 <= lowSync1;
      end
   end

   // =======================================================
   // Reset sources
   // =======================================================
   // Pin low for two slow ticks counts as a request
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pinLowCount <= 2'd0;
      end else if (pinSync2) begin
         pinLowCount <= 2'd0;
      end else if (slowTick && pinLowCount != `PIN_LOW_TICKS) begin
         pinLowCount <= pinLowCount + 2'd1;
      end
   end

   assign extReq = pinRstOn & (pinLowCount == `PIN_LOW_TICKS);
   // Low-voltage reset, off by bit or by power save asleep
   assign lowReq = lowSync2 & ~aux_control_two[`AUX_CONTROL_TWO_LOW_OFF]
                   & ~(aux_control_two[`AUX_CONTROL_TWO_POWER_SAVE] & sleeping);
   assign anyReq = extReq | swReq | dogReq | lowReq;

   // =======================================================
   // Sequencer
   // =======================================================
   // Warm-up, config fetch, hold and release on slow ticks
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state        <= ST_WARM;
         warmCount    <= 21'd0;
         loadIdx      <= 3'd0;
         loadPend     <= 1'b0;
         cfgAddr      <= 16'h0000;
         cfgRead      <= 1'b0;
         releaseTicks <= 2'd0;
         devRst_n     <= 1'b0;
         for (i = 0; i < `CFG_BYTES; i = i + 1) begin
            configWords[i] <= 8'h00;
         end
      end else begin
         cfgRead  <= 1'b0;
         loadPend <= cfgRead;
         // Capture the byte one cycle after its strobe
         if (loadPend) begin
            configWords[loadIdx - 3'd1] <= cfgRdData;
         end
         case (state)
            ST_WARM: begin
               // Hold through warm-up after power-on
               if (warmCount == WARMUP_CYCLES - 1) begin
                  state <= ST_LOAD;
               end else begin
                  warmCount <= warmCount + 21'd1;
               end
            end
            ST_LOAD: begin
               // Issue six reads, then wait for the last byte
               if (loadIdx < `CFG_BYTES && !cfgRead) begin
                  cfgAddr <= `CFG_BASE_ADDR + {13'd0, loadIdx};
                  cfgRead <= 1'b1;
                  loadIdx <= loadIdx + 3'd1;
               end else if (loadIdx == `CFG_BYTES && !cfgRead
                            && !loadPend) begin
                  state        <= ST_HOLD;
                  releaseTicks <= 2'd0;
               end
            end
            ST_HOLD: begin
               // Release synchronously once sources stay away
               if (anyReq) begin
                  releaseTicks <= 2'd0;
               end else if (slowTick) begin
                  if (releaseTicks == `RELEASE_TICKS - 1) begin
                     state    <= ST_RUN;
                     devRst_n <= 1'b1;
                  end else begin
                     releaseTicks <= releaseTicks + 2'd1;
                  end
               end
            end
            ST_RUN: begin
               // Any source takes the device down at once
               if (anyReq) begin
                  state        <= ST_HOLD;
                  devRst_n     <= 1'b0;
                  releaseTicks <= 2'd0;
               end
            end
            default: begin
               state <= ST_WARM;
            end
         endcase
      end
   end

   // =======================================================
   // Special-function registers
   // =======================================================
   // Defaults while in reset, writes only when running
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         option_select   <= `OPT_RESET;
         aux_control_two <= `AUX_CONTROL_TWO_RESET;
         aux_control_one <= `AUX_CONTROL_ONE_RESET;
         swReq           <= 1'b0;
      end else if (inReset) begin
         option_select   <= `OPT_RESET;
         aux_control_two <= `AUX_CONTROL_TWO_RESET;
         aux_control_one <= `AUX_CONTROL_ONE_RESET;
         swReq           <= 1'b0;
      end else begin
         swReq <= 1'b0;
         // Clear bit lasts one cycle only
         aux_control_one[`AUX_CONTROL_ONE_DOG_CLEAR] <= 1'b0;
         if (apbWr) begin
            case (paddr)
               byteAddr(`IDX_OPTION_SELECT): begin
                  option_select <= pwdata[7:0] & `OPT_WRITE_MASK;
               end
               byteAddr(`IDX_SOFTWARE_COMMAND): begin
                  swReq <= (pwdata[7:0] == `SW_RESET_CODE);
               end
               byteAddr(`IDX_AUX_CONTROL_TWO): begin
                  aux_control_two <= pwdata[7:0] & `AUX_CONTROL_TWO_WRITE_MASK;
               end
               byteAddr(`IDX_AUX_CONTROL_ONE): begin
                  aux_control_one <= pwdata[7:0];
               end
               default: begin
                  swReq <= 1'b0;
               end
            endcase
         end
      end
   end

   // =======================================================
   // Reset cause, kept across run-time resets
   // =======================================================
   // Bits: 3 low supply, 2 watchdog, 1 software, 0 pin
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         resetCause <= 4'h0;
      end else if (state == ST_RUN && anyReq) begin
         resetCause <= {lowReq, dogReq, swReq, extReq};
      end
   end

   // =======================================================
   // Watchdog
   // =======================================================
   assign dogRun   = (dogEn == `DOG_EN_ALWAYS) | ~sleeping;
   assign dogLimit = (DOG_BASE_TICKS[15:0]
                     << (2'd3 - option_select[`OPT_PERIOD_HI:`OPT_PERIOD_LO]))
                     - 16'd1;

   // Counts slow ticks; cleared by reset or clear bit
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_counter <= 16'h0000;
         dogReq           <= 1'b0;
      end else if (inReset || aux_control_one[`AUX_CONTROL_ONE_DOG_CLEAR]) begin
         watchdog_counter <= 16'h0000;
         dogReq           <= 1'b0;
      end else begin
         dogReq <= 1'b0;
         if (slowTick && dogRun) begin
            if (watchdog_counter >= dogLimit) begin
               watchdog_counter <= 16'h0000;
               // Overflow resets only when enabled for this mode
               dogReq <= dogEn[1] & ((dogEn == `DOG_EN_ALWAYS)
                         | ~sleeping);
            end else begin
               watchdog_counter <= watchdog_counter + 16'd1;
            end
         end
      end
   end

   // =======================================================
   // Outputs to clocking and supply monitor
   // =======================================================
   // Level select from config; slow mode forced in reset
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_supply_level_sel <= 3'b000;
         slowModeForce        <= 1'b1;
      end else begin
         low_supply_level_sel <=
            configWords[`CFG_BYTES-1][`CFG_LEVEL_HI:`CFG_LEVEL_LO];
         slowModeForce <= inReset;
      end
   end

   // =======================================================
   // APB slave
   // =======================================================
   assign mapped = (paddr == byteAddr(`IDX_OPTION_SELECT))
                 | (paddr == byteAddr(`IDX_SOFTWARE_COMMAND))
                 | (paddr == byteAddr(`IDX_AUX_CONTROL_TWO))
                 | (paddr == byteAddr(`IDX_AUX_CONTROL_ONE))
                 | (paddr == byteAddr(`IDX_CONFIG_WORD_HIGH))
                 | (paddr == byteAddr(`IDX_RESET_CAUSE));

   // Read mux
   always @* begin
      case (paddr)
         byteAddr(`IDX_OPTION_SELECT):    rdByte = option_select;
         byteAddr(`IDX_AUX_CONTROL_TWO):  rdByte = aux_control_two;
         byteAddr(`IDX_AUX_CONTROL_ONE):  rdByte = aux_control_one;
         byteAddr(`IDX_CONFIG_WORD_HIGH): rdByte = configWords[`CFG_BYTES-1];
         byteAddr(`IDX_RESET_CAUSE):      rdByte = {4'h0, resetCause};
         default:                         rdByte = 8'h00;
      endcase
   end

   // One wait cycle, then ready with data and error
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
         end
      end
   end

endmodule // reset_source_and_watchdog_ctrl

// File: bench/reset_ctrl_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// Port checks: bus timing, warm-up, config fetch, resets
// ==========================================================
module reset_ctrl_monitor #(
   parameter WARMUP_CYCLES = 50 // Warm-up length in clocks
) (
   input logic        clk,
   input logic        arst_n,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [15:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [15:0] cfgAddr,
   input logic        cfgRead,
   input logic        devRst_n,
   input logic        slowModeForce
);
   int warm; // Clocks since power-on release, saturating
   // Count the warm-up span
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         warm <= 0;
      else if (warm < WARMUP_CYCLES)
         warm <= warm + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_err;
      pslverr |-> pready && prdata == 32'h0000_0000;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_warm;
      warm < WARMUP_CYCLES |-> !devRst_n && !cfgRead;
   endproperty
   a_warm: assert property (p_warm)
      else $error("warm-up cut");
   property p_cfgRange;
      cfgRead |-> cfgAddr >= 16'h3FFA && cfgAddr <= 16'h3FFF;
   endproperty
   a_cfgRange: assert property (p_cfgRange)
      else $error("config address out of range");
   property p_cfgStep;
      cfgRead && cfgAddr != 16'h3FFF
         |=> !cfgRead ##1 cfgRead && cfgAddr == $past(cfgAddr, 2) + 16'h0001;
   endproperty
   a_cfgStep: assert property (p_cfgStep)
      else $error("config fetch order broken");
   property p_sw;
      psel && penable && pready && pwrite && paddr == 16'h025C
         && pwdata[7:0] == 8'h56 && devRst_n |-> ##[1:2] !devRst_n;
   endproperty
   a_sw: assert property (p_sw)
      else $error("no command reset");
   property p_hold;
      $fell(devRst_n) |=> !devRst_n [*8];
   endproperty
   a_hold: assert property (p_hold)
      else $error("reset too short");
   property p_slow;
      !devRst_n [*2] |-> slowModeForce;
   endproperty
   a_slow: assert property (p_slow)
      else $error("slow mode not held");
endmodule // reset_ctrl_monitor

bind reset_source_and_watchdog_ctrl reset_ctrl_monitor #(
   .WARMUP_CYCLES(WARMUP_CYCLES)
) i_mon (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cfgAddr(cfgAddr),
   .cfgRead(cfgRead), .devRst_n(devRst_n), .slowModeForce(slowModeForce));

// File: bench/rst_far_side.sv
`timescale 1ns/10ps
// ==========================================================
// Far side: pin, supply monitor, slow RC, config bytes
// ==========================================================
module rst_far_side (
   input  logic        clk,
   input  logic [15:0] cfgAddr,
   input  logic        cfgRead,
   input  logic        pinReq,    // Bench asks for a pin pulse
   input  logic        lowReq,    // Bench asks for low supply
   input  logic [7:0]  cfgHigh,   // Top config byte
   output logic [7:0]  cfgRdData,
   output logic        slow_rc_osc,
   output logic        ext_pin_rst_n,
   output logic        lowSupply
);
   initial begin
      slow_rc_osc = 0;
      ext_pin_rst_n = 1;
      cfgRdData = 8'h00;
   end
   // Free-running 68 kHz oscillator
   always #7353 slow_rc_osc = ~slow_rc_osc;
   // Pin held low three slow ticks, above the minimum
   always @(posedge pinReq) begin
      ext_pin_rst_n = 0;
      repeat (3) @(posedge slow_rc_osc);
      ext_pin_rst_n = 1;
   end
   assign lowSupply = lowReq;
   // Byte valid the cycle after the strobe, churning otherwise
   always @(posedge clk) begin
      if (cfgRead)
         cfgRdData <= (cfgAddr == 16'h3FFF) ? cfgHigh : cfgAddr[7:0];
      else
         cfgRdData <= ~cfgRdData;
   end
endmodule // rst_far_side

// File: bench/test_reset_source_and_watchdog_ctrl.sv
`timescale 1ns/10ps
`include "reset_ctrl_map.vh"
// ==========================================================
// Self-checking bench
// ==========================================================
module test_reset_source_and_watchdog_ctrl;
   logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 0, cfgAddr;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0]  cfgRdData, cfgHigh = 0;
   logic [2:0]  lvl;
   logic [1:0]  cpuMode = 0;
   logic        pinReq = 0, lowReq = 0, er, pready, pslverr, cfgRead;
   logic        ext_pin_rst_n, slow_rc_osc, lowSupply, devRst_n, slowMode;
   int          num_errors = 0, check_count = 0;
   always #12.5 clk = ~clk;
   reset_source_and_watchdog_ctrl #(.WARMUP_CYCLES(50), .DOG_BASE_TICKS(8))
   i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_pin_rst_n(ext_pin_rst_n),
      .slow_rc_osc(slow_rc_osc), .lowSupply(lowSupply), .cpuMode(cpuMode),
      .cfgAddr(cfgAddr), .cfgRead(cfgRead), .cfgRdData(cfgRdData),
      .devRst_n(devRst_n), .slowModeForce(slowMode),
      .low_supply_level_sel(lvl));
   rst_far_side i_far (.clk(clk), .cfgAddr(cfgAddr), .cfgRead(cfgRead),
      .pinReq(pinReq), .lowReq(lowReq), .cfgHigh(cfgHigh),
      .cfgRdData(cfgRdData), .slow_rc_osc(slow_rc_osc),
      .ext_pin_rst_n(ext_pin_rst_n), .lowSupply(lowSupply));
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task results;
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One APB transfer, held until ready
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= idx << 2;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         chk(pready, 1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   // Read and compare one register
   task rdc(input logic [15:0] idx, input logic [7:0] e);
      apb(0, idx, 8'h00);
      chk(rd, {24'h00_0000, e});
   endtask
   // Bounded wait for a reset level
   task waitLvl(input logic v, input int n);
      int i;
      for (i = 0; i < n && devRst_n !== v; i++)
         @(posedge clk);
      chk(devRst_n, v);
   endtask
   // Power-on with a given top config byte
   task powerUp(input logic [7:0] c);
      @(posedge clk);
      arst_n <= 0;
      cfgHigh <= c;
      repeat (5) @(posedge clk);
      arst_n <= 1;
      apb(1, `IDX_OPTION_SELECT, 8'h30);
      waitLvl(1, 3000);
      chk(lvl, c[5:3]);
      rdc(`IDX_CONFIG_WORD_HIGH, c);
      rdc(`IDX_OPTION_SELECT, `OPT_RESET);
   endtask
   // Pin pulse request
   task pin;
      @(posedge clk);
      pinReq <= 1;
      @(posedge clk);
      pinReq <= 0;
   endtask
   initial begin
      int i;
      logic [7:0] v;
      v = $urandom(32'h4707716d);
      for (i = 0; i < 8; i++) begin
         v = $urandom;
         powerUp({v[7], 1'b1, i[2:0], v[2:0]});
      end
      rdc(`IDX_AUX_CONTROL_TWO, `AUX_CONTROL_TWO_RESET);
      rdc(`IDX_AUX_CONTROL_ONE, `AUX_CONTROL_ONE_RESET);
      rdc(`IDX_SOFTWARE_COMMAND, 8'h00);
      rdc(16'h0010, 8'h00);
      chk(er, 1);
      // Random option writes keep writable bits only
      repeat (4) begin
         v = $urandom;
         apb(1, `IDX_OPTION_SELECT, v);
         rdc(`IDX_OPTION_SELECT, v & `OPT_WRITE_MASK);
      end
      apb(1, `IDX_AUX_CONTROL_ONE, 8'h80);
      rdc(`IDX_AUX_CONTROL_ONE, 8'h00);
      // Wrong command code, then the real one
      apb(1, `IDX_SOFTWARE_COMMAND, 8'h55);
      chk(devRst_n, 1);
      apb(1, `IDX_SOFTWARE_COMMAND, `SW_RESET_CODE);
      waitLvl(0, 4);
      waitLvl(1, 3000);
      rdc(`IDX_RESET_CAUSE, 8'h02);
      rdc(`IDX_OPTION_SELECT, 8'h00);
      // Pin reset with the enable bit set
      pin;
      waitLvl(0, 2000);
      waitLvl(1, 4000);
      rdc(`IDX_RESET_CAUSE, 8'h01);
      // Always-on watchdog, shortest period, kept cleared
      apb(1, `IDX_OPTION_SELECT, 8'h30);
      apb(1, `IDX_AUX_CONTROL_TWO, 8'hC0);
      repeat (6) begin
         cpuMode <= $urandom;
         repeat (1500) @(posedge clk);
         apb(1, `IDX_AUX_CONTROL_ONE, 8'h80);
      end
      chk(devRst_n, 1);
      waitLvl(0, 6000);
      cpuMode <= 0;
      waitLvl(1, 3000);
      rdc(`IDX_RESET_CAUSE, 8'h04);
      rdc(`IDX_AUX_CONTROL_TWO, `AUX_CONTROL_TWO_RESET);
      // Run-only enable, doubled period: idle holds it, waking fires
      apb(1, `IDX_OPTION_SELECT, 8'h20);
      apb(1, `IDX_AUX_CONTROL_TWO, 8'h80);
      cpuMode <= 2;
      repeat (7000) @(posedge clk);
      chk(devRst_n, 1);
      cpuMode <= 0;
      // Past the shortest period, still short of the doubled one
      repeat (6000) @(posedge clk);
      chk(devRst_n, 1);
      waitLvl(0, 6000);
      waitLvl(1, 3000);
      // Low supply: off bit, then power save asleep, then awake
      apb(1, `IDX_AUX_CONTROL_TWO, 8'h21);
      lowReq <= 1;
      cpuMode <= 3;
      repeat (1500) @(posedge clk);
      chk(devRst_n, 1);
      apb(1, `IDX_AUX_CONTROL_TWO, 8'h20);
      repeat (1500) @(posedge clk);
      chk(devRst_n, 1);
      cpuMode <= 0;
      waitLvl(0, 100);
      lowReq <= 0;
      waitLvl(1, 3000);
      rdc(`IDX_RESET_CAUSE, 8'h08);
      // Pin ignored when the config byte disables it
      powerUp(8'h00);
      pin;
      repeat (3000) @(posedge clk);
      chk(devRst_n, 1);
      results;
   end
   // Timeout: run needs about 1.3 ms, cut off at 2.5 ms
   initial begin
      #2_500_000;
      num_errors++;
      results;
   end
endmodule // test_reset_source_and_watchdog_ctrl
